/* core/mbs_slave.sv */
/*
 * mbs_slave: slave command interpreter with response fifo.
 * assumes a byte receiver that strobes data bits only and flags the
 * 3.5 character silence, a byte transmitter draining the fifo, and a
 * parameter store answering requests and per-parameter attributes.
 */
// Behaviour
// - each message carries a sixteen-bit crc
// - check received crc, append crc to replies
// - crc register starts at FFFF per message
// - only eight data bits enter crc
// - xor byte, eight right shifts with polynomial A001
// - final register value is the crc
// - crc low byte sent before high byte
// - high byte selects group, low byte index
// - factory factory_param_group refused entirely
// - monitor group read only
// - run-locked and never-writable parameters refuse writes
// - F0-FE and A0-AC map to ram
// - alias high bytes write ram only
// - reading an alias address is an error
// - command 07 writes ram only
// - percent values signed, 10000 is 100 percent
// - frequency reference scales max frequency
// - command word codes one to seven
// - word read 03, write 06 and ram write 07 only
// - silence of 3.5 characters ends message
// - own address answers, broadcast acts silently
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// response fifo
// ------------------------------------------------------------
module mbs_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	mbs_pkg::mbs_fifo_state_t s_r, s_nxt; // whole fifo state
	logic push, pop;
	assign in_ready_o = (s_r.cnt != 4'(D)); // full blocks the producer
	assign out_valid_o = (s_r.cnt != 4'h0);
	assign out_data_o = s_r.mem[s_r.rp];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	// pointer and count update
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp = s_r.wp + 3'h1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 3'h1;
		end
		s_nxt.cnt = s_r.cnt + (push ? 4'h1 : 4'h0) - (pop ? 4'h1 : 4'h0);
	end
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : mbs_fifo

// ------------------------------------------------------------
// slave top
// ------------------------------------------------------------
module mbs_slave (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] my_addr_i, // own station address
	input wire logic [7:0] rx_byte_i, // data bits only
	input wire logic rx_valid_i,
	input wire logic rx_gap_i, // silence of 3.5 characters seen
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic par_req_o, // level until par_ack_i
	output logic par_we_o,
	output logic par_ram_only_o, // skip eeprom storage
	output logic [7:0] par_group_o,
	output logic [7:0] par_index_o,
	output logic [15:0] par_ram_addr_o,
	output logic [15:0] par_wdata_o,
	input wire logic par_ack_i,
	input wire logic [15:0] par_rdata_i,
	input wire logic par_lock_run_i, // attribute of addressed parameter
	input wire logic par_lock_never_i,
	input wire logic drive_running_i,
	input wire logic [15:0] max_frequency_param_i,
	output logic [2:0] run_cmd_o,
	output logic run_cmd_stb_o,
	output logic [15:0] freq_ref_o,
	output logic freq_ref_stb_o,
	output logic frame_err_o
);
	mbs_pkg::mbs_slave_state_t s_r, s_nxt; // whole block state
	logic push_valid, push_ready; // producer side of the fifo
	logic [7:0] push_data;
	logic [7:0] cmd, hi, lo; // request fields
	logic [15:0] val;
	logic rd, wr, is_main, is_ext, is_mon, is_amain, is_aext;
	logic signed [32:0] prod;
	assign cmd = s_r.fr[1];
	assign hi = s_r.fr[2];
	assign lo = s_r.fr[3];
	assign val = {s_r.fr[4], s_r.fr[5]};
	assign rd = (cmd == mbs_pkg::CMD_READ);
	assign wr = (cmd == mbs_pkg::CMD_WRITE) || (cmd == mbs_pkg::CMD_WRITE_RAM);
	assign is_main = (hi[7:4] == mbs_pkg::MAIN_NIB) && (hi != mbs_pkg::FACTORY_PARAM_GROUP);
	assign is_ext = (hi[7:4] == mbs_pkg::EXT_NIB) && (hi[3:0] <= mbs_pkg::EXT_LAST_GRP);
	assign is_mon = (hi[7:4] == mbs_pkg::MON_NIB);
	assign is_amain = (hi[7:4] == mbs_pkg::MAIN_ALIAS_NIB) && ({mbs_pkg::MAIN_NIB, hi[3:0]} != mbs_pkg::FACTORY_PARAM_GROUP);
	assign is_aext = (hi[7:4] == mbs_pkg::EXT_ALIAS_NIB) && (hi[3:0] <= mbs_pkg::EXT_LAST_GRP);
	// reference as a share of maximum frequency
	assign prod = 33'($signed(val)) * $signed({17'h00000, max_frequency_param_i});

	// outputs from state flops
	assign par_req_o = s_r.par_req;
	assign par_we_o = s_r.par_we;
	assign par_ram_only_o = s_r.ram_only;
	assign par_group_o = s_r.grp;
	assign par_index_o = s_r.idx;
	assign par_ram_addr_o = s_r.ram_addr;
	assign par_wdata_o = s_r.wdata;
	assign run_cmd_o = s_r.run_cmd;
	assign run_cmd_stb_o = s_r.run_stb;
	assign freq_ref_o = s_r.freq_ref;
	assign freq_ref_stb_o = s_r.freq_stb;
	assign frame_err_o = s_r.frame_err;

	// response byte offered to the fifo
	always_comb begin
		push_valid = (s_r.st == mbs_pkg::MBS_RESP);
		case (s_r.cphase)
			2'h0: push_data = s_r.rsp[s_r.ridx];
			2'h1: push_data = s_r.crc[7:0];
			default: push_data = s_r.crc[15:8];
		endcase
	end

	// main sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.run_stb = 1'b0;
		s_nxt.freq_stb = 1'b0;
		s_nxt.frame_err = 1'b0;
		case (s_r.st)
			mbs_pkg::MBS_RX: begin
				if (rx_valid_i) begin
					if (s_r.cnt < mbs_pkg::REQ_LEN) begin
						s_nxt.fr[s_r.cnt[2:0]] = rx_byte_i;
						s_nxt.crc = mbs_pkg::mbs_crc_byte(s_r.crc, rx_byte_i);
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else begin
						s_nxt.ovf = 1'b1; // too long, drop at the gap
					end
				end else if (rx_gap_i && (s_r.cnt != 4'h0)) begin
					s_nxt.st = mbs_pkg::MBS_CHK;
				end
			end
			mbs_pkg::MBS_CHK: begin
				s_nxt.st = mbs_pkg::MBS_RX;
				s_nxt.cnt = 4'h0;
				s_nxt.ovf = 1'b0;
				s_nxt.crc = mbs_pkg::CRC_INIT;
				s_nxt.bcast = (s_r.fr[0] == mbs_pkg::BCAST_ADDR);
				s_nxt.rsp = {16'h0000, 8'h00, mbs_pkg::EXC_ADDR, cmd | mbs_pkg::EXC_FLAG, s_r.fr[0]};
				s_nxt.rlen = 3'h3;
				// residue over data plus check field is zero
				if (s_r.ovf || (s_r.cnt != mbs_pkg::REQ_LEN) || (s_r.crc != 16'h0000)) begin
					s_nxt.frame_err = 1'b1; // corrupt frames get no answer
				end else if ((s_r.fr[0] != my_addr_i) && (s_r.fr[0] != mbs_pkg::BCAST_ADDR)) begin
					s_nxt.st = mbs_pkg::MBS_RX;
				end else begin
					s_nxt.st = mbs_pkg::MBS_RESP; // default: echo answer
					s_nxt.rsp[5:4] = {val[7:0], val[15:8]};
					s_nxt.rsp[1] = cmd;
					s_nxt.rsp[2] = hi;
					s_nxt.rsp[3] = lo;
					s_nxt.rlen = 3'h6; // echo of a write
					if (!rd && !wr) begin
						s_nxt.rsp[1] = cmd | mbs_pkg::EXC_FLAG;
						s_nxt.rsp[2] = mbs_pkg::EXC_FUNC;
						s_nxt.rlen = 3'h3;
					end else if ({hi, lo} == mbs_pkg::RUN_CONTROL_COMMAND) begin
						// command word, codes one to seven
						if (wr && (val[15:3] == 13'h0000) && (val[2:0] >= mbs_pkg::RUN_FIRST)
							&& (val[2:0] <= mbs_pkg::RUN_LAST)) begin
							s_nxt.run_cmd = val[2:0];
							s_nxt.run_stb = 1'b1;
						end else begin
							s_nxt.rsp[1] = cmd | mbs_pkg::EXC_FLAG;
							s_nxt.rsp[2] = wr ? mbs_pkg::EXC_VALUE : mbs_pkg::EXC_ADDR;
							s_nxt.rlen = 3'h3;
						end
					end else if ({hi, lo} == mbs_pkg::FREQ_REF_ADDR) begin
						// signed percent within plus and minus 100.00
						if (wr && ($signed(val) <= mbs_pkg::PCT_MAX) && ($signed(val) >= mbs_pkg::PCT_MIN)) begin
							s_nxt.freq_ref = 16'(prod / mbs_pkg::PCT_SCALE);
							s_nxt.freq_stb = 1'b1;
						end else begin
							s_nxt.rsp[1] = cmd | mbs_pkg::EXC_FLAG;
							s_nxt.rsp[2] = wr ? mbs_pkg::EXC_VALUE : mbs_pkg::EXC_ADDR;
							s_nxt.rlen = 3'h3;
						end
					// factory group and unknown groups refused
					// alias read is an invalid address
					end else if ((is_main || is_ext || (is_mon && rd) || ((is_amain || is_aext) && wr))) begin
						s_nxt.st = mbs_pkg::MBS_ATTR;
						s_nxt.par_we = wr;
						s_nxt.ram_only = is_amain || is_aext || (cmd == mbs_pkg::CMD_WRITE_RAM);
						s_nxt.grp = is_amain ? {mbs_pkg::MAIN_NIB, hi[3:0]}
							: (is_aext ? {mbs_pkg::EXT_NIB, hi[3:0]} : hi);
						s_nxt.idx = lo;
						s_nxt.wdata = val;
						s_nxt.ram_addr = (is_main || is_amain) ? {mbs_pkg::MAIN_RAM_NIB, hi[3:0], lo}
							: ((is_ext || is_aext) ? {mbs_pkg::EXT_RAM_NIB, hi[3:0], lo} : {hi, lo});
					end else begin
						s_nxt.rsp[1] = cmd | mbs_pkg::EXC_FLAG;
						s_nxt.rsp[2] = mbs_pkg::EXC_ADDR;
						s_nxt.rlen = 3'h3;
					end
					if (s_r.fr[0] == mbs_pkg::BCAST_ADDR) begin
						s_nxt.st = (s_nxt.st == mbs_pkg::MBS_ATTR) ? mbs_pkg::MBS_ATTR : mbs_pkg::MBS_RX;
					end
				end
			end
			mbs_pkg::MBS_ATTR: begin
				// attributes answer to the address shown in this same cycle
				// lock attributes refuse writes
				if (s_r.par_we && (par_lock_never_i || (par_lock_run_i && drive_running_i))) begin
					s_nxt.rsp[1] = cmd | mbs_pkg::EXC_FLAG;
					s_nxt.rsp[2] = mbs_pkg::EXC_LOCK;
					s_nxt.rlen = 3'h3;
					s_nxt.st = s_r.bcast ? mbs_pkg::MBS_RX : mbs_pkg::MBS_RESP;
				end else begin
					s_nxt.par_req = 1'b1;
					s_nxt.st = mbs_pkg::MBS_ACC;
				end
			end
			mbs_pkg::MBS_ACC: begin
				if (par_ack_i) begin
					s_nxt.par_req = 1'b0;
					s_nxt.st = s_r.bcast ? mbs_pkg::MBS_RX : mbs_pkg::MBS_RESP;
					if (!s_r.par_we) begin
						s_nxt.rsp[2] = 8'h02; // byte count of one word
						s_nxt.rsp[3] = par_rdata_i[15:8];
						s_nxt.rsp[4] = par_rdata_i[7:0];
						s_nxt.rlen = 3'h5;
					end
				end
			end
			mbs_pkg::MBS_RESP: begin
				// a full fifo stalls the reply here
				if (push_ready) begin
					if (s_r.cphase == 2'h0) begin
						s_nxt.crc = mbs_pkg::mbs_crc_byte(s_r.crc, push_data);
						s_nxt.ridx = s_r.ridx + 3'h1;
						s_nxt.cphase = (s_r.ridx + 3'h1 == s_r.rlen) ? 2'h1 : 2'h0;
					end else if (s_r.cphase == 2'h1) begin
						s_nxt.cphase = 2'h2;
					end else begin
						s_nxt.st = mbs_pkg::MBS_RX;
						s_nxt.cphase = 2'h0;
						s_nxt.ridx = 3'h0;
						s_nxt.crc = mbs_pkg::CRC_INIT;
					end
				end
			end
			default: s_nxt.st = mbs_pkg::MBS_RX;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.st <= mbs_pkg::MBS_RX;
			s_r.crc <= mbs_pkg::CRC_INIT;
		end else begin
			s_r <= s_nxt;
		end
	end

	// reply path, the transmitter may stall it
	mbs_fifo #(
		.W(mbs_pkg::FIFO_W),
		.D(mbs_pkg::FIFO_D)
	) u_fifo (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(push_data),
		.out_valid_o(tx_valid_o),
		.out_ready_i(tx_ready_i),
		.out_data_o(tx_data_o)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_crc_init;
		@(posedge clock_i) disable iff (rst_i) (s_r.st != mbs_pkg::MBS_RX) ##1 (s_r.st == mbs_pkg::MBS_RX)
			|-> (s_r.crc == 16'hFFFF) && (s_r.cnt == 4'h0);
	endproperty
	a_crc_init: assert property (p_crc_init) else $error("crc not preset");
	property p_crc_step;
		@(posedge clock_i) disable iff (rst_i) (s_r.st == mbs_pkg::MBS_RX) && rx_valid_i && (s_r.cnt < 4'h8)
			|=> s_r.crc == mbs_pkg::mbs_crc_byte($past(s_r.crc), $past(rx_byte_i));
	endproperty
	a_crc_step: assert property (p_crc_step) else $error("crc step wrong");
	property p_factory;
		@(posedge clock_i) disable iff (rst_i) par_req_o |-> par_group_o != 8'hFF;
	endproperty
	a_factory: assert property (p_factory) else $error("factory group accessed");
	property p_monitor;
		@(posedge clock_i) disable iff (rst_i) par_req_o && par_we_o |-> par_group_o[7:4] != 4'h7;
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor write");
	property p_lock;
		@(posedge clock_i) disable iff (rst_i) (s_r.st == mbs_pkg::MBS_ATTR) && s_r.par_we && par_lock_never_i
			|=> !par_req_o [*2];
	endproperty
	a_lock: assert property (p_lock) else $error("locked write issued");
	property p_map;
		@(posedge clock_i) disable iff (rst_i) par_req_o && (par_group_o[7:4] == 4'hF)
			|-> par_ram_addr_o == {4'h0, par_group_o[3:0], par_index_o};
	endproperty
	a_map: assert property (p_map) else $error("main group ram address");
	property p_alias;
		@(posedge clock_i) disable iff (rst_i) par_req_o && par_ram_only_o |-> par_we_o;
	endproperty
	a_alias: assert property (p_alias) else $error("ram only read");
	property p_bcast;
		@(posedge clock_i) disable iff (rst_i) push_valid |-> !s_r.bcast;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast answered");
	property p_run;
		@(posedge clock_i) disable iff (rst_i) run_cmd_stb_o |-> (run_cmd_o != 3'h0) ##1 !run_cmd_stb_o;
	endproperty
	a_run: assert property (p_run) else $error("bad run command");
endmodule : mbs_slave
`default_nettype wire

/* core/mbs_pkg.sv */
/*
 * mbs_pkg: constants, types and the byte-wise crc step for the serial slave
 * command block. assumes one system clock and a synchronous active-high reset.
 */
`default_nettype none
package mbs_pkg;
	// ------------------------------------------------------------
	// crc and framing
	// ------------------------------------------------------------
	localparam logic [15:0] CRC_INIT = 16'hFFFF; // register preset per message
	localparam logic [15:0] CRC_POLY = 16'hA001; // reflected polynomial
	localparam logic [3:0] REQ_LEN = 4'h8; // every accepted request is 8 bytes
	localparam int FIFO_W = 8; // response fifo width
	localparam int FIFO_D = 8; // response fifo depth
	// ------------------------------------------------------------
	// command codes and exception codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE = 8'h06;
	localparam logic [7:0] CMD_WRITE_RAM = 8'h07;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_FUNC = 8'h01; // unknown command
	localparam logic [7:0] EXC_ADDR = 8'h02; // invalid or refused address
	localparam logic [7:0] EXC_VALUE = 8'h03; // value out of range
	localparam logic [7:0] EXC_LOCK = 8'h04; // write locked by attribute
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam logic [15:0] RUN_CONTROL_COMMAND = 16'h2000; // write only
	localparam logic [15:0] FREQ_REF_ADDR = 16'h1000; // link frequency reference
	localparam logic [7:0] FACTORY_PARAM_GROUP = 8'hFF;
	localparam logic [3:0] MAIN_NIB = 4'hF;
	localparam logic [3:0] EXT_NIB = 4'hA;
	localparam logic [3:0] MON_NIB = 4'h7;
	localparam logic [3:0] MAIN_ALIAS_NIB = 4'h0;
	localparam logic [3:0] EXT_ALIAS_NIB = 4'h4;
	localparam logic [3:0] EXT_LAST_GRP = 4'hC; // extended groups end at AC
	localparam logic [3:0] MAIN_RAM_NIB = 4'h0;
	localparam logic [3:0] EXT_RAM_NIB = 4'h4;
	localparam logic [2:0] RUN_FIRST = 3'h1; // forward run
	localparam logic [2:0] RUN_LAST = 3'h7; // fault reset
	localparam logic signed [15:0] PCT_MAX = 16'sh2710; // +100.00 percent
	localparam logic signed [15:0] PCT_MIN = -16'sh2710; // -100.00 percent
	localparam logic signed [32:0] PCT_SCALE = 33'sh0_0000_2710;
	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MBS_RX = 3'b000,
		MBS_CHK = 3'b001,
		MBS_ATTR = 3'b010,
		MBS_ACC = 3'b011,
		MBS_RESP = 3'b100
	} mbs_state_t;
	typedef struct packed {
		mbs_state_t st;
		logic [7:0][7:0] fr; // received request bytes
		logic [3:0] cnt;
		logic ovf;
		logic [15:0] crc;
		logic [5:0][7:0] rsp; // response body before crc
		logic [2:0] rlen;
		logic [2:0] ridx;
		logic [1:0] cphase; // 0 body, 1 crc low, 2 crc high
		logic bcast;
		logic par_req;
		logic par_we;
		logic ram_only;
		logic [15:0] ram_addr;
		logic [15:0] wdata;
		logic [7:0] grp;
		logic [7:0] idx;
		logic [2:0] run_cmd;
		logic run_stb;
		logic [15:0] freq_ref;
		logic freq_stb;
		logic frame_err;
	} mbs_slave_state_t;
	typedef struct packed {
		logic [FIFO_D-1:0][FIFO_W-1:0] mem;
		logic [2:0] wp;
		logic [2:0] rp;
		logic [3:0] cnt;
	} mbs_fifo_state_t;
	function automatic logic [15:0] mbs_crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : mbs_crc_byte
endpackage : mbs_pkg
`default_nettype wire

/* dv/mbs_master_model.sv */
/*
 * mbs_master_model: line master in front of the slave block. sends framed
 * requests with their check word and takes reply bytes, stalling on request.
 * assumes the bench calls send() from one process only.
 */
`timescale 1ns/1ns
`default_nettype none
module mbs_master_model (
	input wire logic clock_i,
	input wire logic slow_i, // stall the reply side at random
	output logic [7:0] rx_byte_o,
	output logic rx_valid_o,
	output logic rx_gap_o,
	output logic tx_ready_o
);
	// ----------------------------------------
	// check word
	// ----------------------------------------
	// bitwise check step
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		logic fb;
		r = c;
		// bit-serial form, so it cannot share a slip with a byte-wide one
		for (int k = 0; k < 8; k++) begin
			fb = r[0] ^ b[k];
			r = r >> 1;
			if (fb) r = r ^ 16'hA001;
		end
		return r;
	endfunction : crc_step

	// reply side: ready level, changed only off the sampling edge
	initial begin
		rx_byte_o = 8'hA5;
		rx_valid_o = 1'b0;
		rx_gap_o = 1'b0;
		tx_ready_o = 1'b1;
		forever begin
			@(negedge clock_i);
			tx_ready_o = slow_i ? (($urandom & 1) != 0) : 1'b1;
		end
	end

	// ----------------------------------------
	// request sender
	// ----------------------------------------
	// appended check word, bad flips one bit
	task automatic send(input logic [47:0] f, input logic bad);
		logic [15:0] c;
		logic [63:0] w;
		c = 16'hFFFF;
		for (int i = 0; i < 6; i++) c = crc_step(c, f[47-8*i -: 8]);
		w = {f, c[7:0], c[15:8] ^ {7'h00, bad}};
		for (int i = 0; i < 8; i++) begin
			@(negedge clock_i);
			rx_byte_o = w[63-8*i -: 8];
			rx_valid_o = 1'b1;
		end
		@(negedge clock_i);
		rx_valid_o = 1'b0;
		// stale data is inverted so nobody can rely on it
		rx_byte_o = ~rx_byte_o;
		rx_gap_o = 1'b1;
		@(negedge clock_i);
		rx_gap_o = 1'b0;
	endtask : send
endmodule : mbs_master_model
`default_nettype wire

/* dv/test_mbs_slave.sv */
/*
 * test_mbs_slave: self-checking bench for the slave command block.
 * assumes the master model beside it; the parameter store is emulated here.
 */
`timescale 1ns/1ns
`default_nettype none
module test_mbs_slave;
	logic clock_i, rst_i, slow, par_ack_i, running, lock_run, lock_never;
	logic [7:0] me, rx_byte, tx_data_o, par_group_o, par_index_o;
	logic rx_valid, rx_gap, tx_valid_o, tx_ready, par_req_o, par_we_o, par_ram_only_o;
	logic [15:0] par_ram_addr_o, par_wdata_o, par_rdata_i, rdat, mx, freq_ref_o;
	logic [2:0] run_cmd_o;
	logic run_cmd_stb_o, freq_ref_stb_o, frame_err_o;
	logic preq_d = 1'b0; // request seen last edge
	logic [63:0] q[$]; // expected events, oldest first
	int errors = 0;
	int check_count = 0;

	mbs_master_model m (.clock_i(clock_i), .slow_i(slow), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
		.rx_gap_o(rx_gap), .tx_ready_o(tx_ready));
	mbs_slave dut (.clock_i(clock_i), .rst_i(rst_i), .my_addr_i(me), .rx_byte_i(rx_byte),
		.rx_valid_i(rx_valid), .rx_gap_i(rx_gap), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
		.tx_ready_i(tx_ready), .par_req_o(par_req_o), .par_we_o(par_we_o), .par_ram_only_o(par_ram_only_o),
		.par_group_o(par_group_o), .par_index_o(par_index_o), .par_ram_addr_o(par_ram_addr_o),
		.par_wdata_o(par_wdata_o), .par_ack_i(par_ack_i), .par_rdata_i(par_rdata_i),
		.par_lock_run_i(lock_run), .par_lock_never_i(lock_never), .drive_running_i(running),
		.max_frequency_param_i(mx), .run_cmd_o(run_cmd_o), .run_cmd_stb_o(run_cmd_stb_o),
		.freq_ref_o(freq_ref_o), .freq_ref_stb_o(freq_ref_stb_o), .frame_err_o(frame_err_o));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// compare and verdict
	// ----------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task test_done;
		if (errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// an event nobody expected meets an all-ones note
	task automatic take(input logic [63:0] seen);
		logic [63:0] e;
		e = 64'hFFFF_FFFF_FFFF_FFFF;
		if (q.size() != 0) e = q.pop_front();
		check(seen, e);
	endtask : take

	// watcher: every observable result is matched against the oldest note
	always @(posedge clock_i) begin
		if (rst_i === 1'b0) begin
			if (par_req_o === 1'b1 && preq_d === 1'b0)
				take(64'({4'h4, par_we_o, par_ram_only_o, par_group_o, par_index_o, par_ram_addr_o,
					par_we_o ? par_wdata_o : 16'h0000}));
			if (run_cmd_stb_o === 1'b1) take(64'({4'h1, 13'h0000, run_cmd_o}));
			if (freq_ref_stb_o === 1'b1) take(64'({4'h2, freq_ref_o}));
			if (frame_err_o === 1'b1) take(64'h3_0000);
			if (tx_valid_o === 1'b1 && tx_ready === 1'b1) take({56'h0, tx_data_o});
		end
		preq_d <= par_req_o;
	end

	// parameter store: answers after a random pause, data inverted after
	initial forever begin
		@(negedge clock_i);
		if (par_req_o === 1'b1) begin
			repeat ($urandom_range(3, 0)) @(negedge clock_i);
			par_ack_i = 1'b1;
			par_rdata_i = rdat;
			@(negedge clock_i);
			par_ack_i = 1'b0;
			par_rdata_i = ~rdat;
		end
	end

	// ----------------------------------------
	// transfer helpers
	// ----------------------------------------
	// reply notes with check word
	task automatic exp_reply(input logic [47:0] f, input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			c = m.crc_step(c, f[47-8*i -: 8]);
			q.push_back({56'h0, f[47-8*i -: 8]});
		end
		q.push_back({56'h0, c[7:0]});
		q.push_back({56'h0, c[15:8]});
	endtask : exp_reply

	// one request; waits for the notes to drain, then for stragglers
	task automatic go(input logic [7:0] a, c, input logic [15:0] ad, dt, input logic bad);
		m.send({a, c, ad, dt}, bad);
		for (int i = 0; i < 400 && q.size() != 0; i++) @(negedge clock_i);
		repeat (12) @(negedge clock_i);
		check(64'(q.size()), 64'h0);
	endtask : go

	task automatic okw(input logic [7:0] c, input logic [15:0] ad, input logic ro, input logic [7:0] g,
		input logic [15:0] ra);
		logic [15:0] wd;
		wd = 16'($urandom);
		q.push_back(64'({4'h4, 1'b1, ro, g, ad[7:0], ra, wd}));
		exp_reply({me, c, ad, wd}, 6);
		go(me, c, ad, wd, 1'b0);
	endtask : okw

	task automatic exc(input logic [7:0] c, input logic [15:0] ad, dt, input logic [7:0] code);
		exp_reply({me, c | 8'h80, code, 24'h0}, 3);
		go(me, c, ad, dt, 1'b0);
	endtask : exc

	task automatic rd(input logic [15:0] ad, input logic [7:0] g, input logic [15:0] ra);
		rdat = 16'($urandom);
		q.push_back(64'({4'h4, 2'b00, g, ad[7:0], ra, 16'h0000}));
		exp_reply({me, 8'h03, 8'h02, rdat, 8'h00}, 5);
		go(me, 8'h03, ad, 16'h0001, 1'b0);
	endtask : rd

	task automatic fr(input logic signed [15:0] v);
		int e;
		e = int'(v) * int'(mx) / 10000;
		q.push_back(64'({4'h2, e[15:0]}));
		exp_reply({me, 8'h06, 16'h1000, v}, 6);
		go(me, 8'h06, 16'h1000, v, 1'b0);
	endtask : fr

	initial begin
		#400000;
		errors++;
		test_done;
	end

	// ----------------------------------------
	// main sequence: all cases prompt, then with reply stalls
	// ----------------------------------------
	initial begin
		void'($urandom(76));
		me = 8'($urandom_range(247, 1));
		mx = 16'($urandom);
		{rst_i, slow, par_ack_i, running, lock_run, lock_never} = 6'b100000;
		rdat = 16'h0000;
		par_rdata_i = 16'h0000;
		repeat (6) @(negedge clock_i);
		rst_i = 1'b0;
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			okw(8'h06, 16'hF30C, 1'b0, 8'hF3, 16'h030C);
			okw(8'h06, 16'hA20B, 1'b0, 8'hA2, 16'h420B);
			okw(8'h06, 16'h030C, 1'b1, 8'hF3, 16'h030C);
			okw(8'h06, 16'h420B, 1'b1, 8'hA2, 16'h420B);
			okw(8'h07, 16'hFE00, 1'b1, 8'hFE, 16'h0E00);
			rd(16'hF30C, 8'hF3, 16'h030C);
			rd(16'h7001, 8'h70, 16'h7001);
			exc(8'h03, 16'hFF00, 16'h0001, 8'h02);
			exc(8'h06, 16'hFF10, 16'h0000, 8'h02);
			exc(8'h06, 16'h0F10, 16'h0000, 8'h02);
			exc(8'h06, 16'h7001, 16'h0000, 8'h02);
			exc(8'h03, 16'h030C, 16'h0001, 8'h02);
			exc(8'h05, 16'hF30C, 16'h0001, 8'h01);
			exc(8'h03, 16'h2000, 16'h0001, 8'h02);
			lock_never = 1'b1;
			exc(8'h06, 16'hF30C, 16'h0001, 8'h04);
			lock_never = 1'b0;
			lock_run = 1'b1;
			running = 1'b1;
			exc(8'h06, 16'hF30C, 16'h0001, 8'h04);
			running = 1'b0;
			okw(8'h06, 16'hF30C, 1'b0, 8'hF3, 16'h030C);
			lock_run = 1'b0;
			// every command word code, and both neighbours outside the set
			for (int v = 0; v <= 8; v++) begin
				if (v == 0 || v == 8) exc(8'h06, 16'h2000, 16'(v), 8'h03);
				else begin
					q.push_back(64'({4'h1, 16'(v)}));
					exp_reply({me, 8'h06, 16'h2000, 16'(v)}, 6);
					go(me, 8'h06, 16'h2000, 16'(v), 1'b0);
				end
			end
			fr(16'sd5000);
			fr(-16'sd2500);
			fr(16'sd10000);
			exc(8'h06, 16'h1000, 16'd10001, 8'h03);
			q.push_back(64'h3_0000);
			go(me, 8'h06, 16'hF30C, 16'h1111, 1'b1);
			q.push_back(64'({4'h4, 2'b10, 8'hF3, 8'h0C, 16'h030C, 16'h5A5A}));
			go(8'h00, 8'h06, 16'hF30C, 16'h5A5A, 1'b0);
			go(me + 8'h01, 8'h06, 16'hF30C, 16'h5A5A, 1'b0);
		end
		test_done;
	end
endmodule : test_mbs_slave
`default_nettype wire
